// *** inc/lsp_pkg.sv ***
// constants, field layout and types of the load/store pointer unit
package lsp_pkg;
  localparam int LSP_XLEN = 64;
  localparam int LSP_REG_W = 6;
  localparam int LSP_STREAM_W = 3;
  localparam int LSP_STEP_W = 9;
  localparam int LSP_BE_W = 8;
  // instruction word field positions
  localparam int LSP_OPC_HI = 31;
  localparam int LSP_OPC_LO = 24;
  localparam int LSP_SIZE_HI = 23;
  localparam int LSP_SIZE_LO = 22;
  localparam int LSP_ENDIAN_BIT = 21;
  localparam int LSP_HINT_HI = 20;
  localparam int LSP_HINT_LO = 18;
  localparam int LSP_IMM_SIGN = 20;
  localparam int LSP_IMM_HI = 19;
  localparam int LSP_IMM_LO = 12;
  localparam int LSP_PTR_HI = 11;
  localparam int LSP_PTR_LO = 6;
  localparam int LSP_DAT_HI = 5;
  localparam int LSP_DAT_LO = 0;
  // opcode values
  localparam logic [7:0] LSP_PLAIN_READ_OPCODE = 8'h01;
  localparam logic [7:0] LSP_PLAIN_WRITE_OPCODE = 8'h02;
  localparam logic [7:0] LSP_POSTINC_READ_OPCODE = 8'h03;
  localparam logic [5:0] LSP_NULL_REGISTER = 6'h00;
  localparam logic LSP_LITTLE_ENDIAN = 1'b0;
  // size flag encodings
  localparam logic [1:0] LSP_SZ_8 = 2'h0;
  localparam logic [1:0] LSP_SZ_16 = 2'h1;
  localparam logic [1:0] LSP_SZ_32 = 2'h2;
  localparam logic [1:0] LSP_SZ_64 = 2'h3;
  // timing in cycles
  localparam int LSP_HIT_LATENCY = 2;
  localparam int LSP_ASU_STAGES = 2;
  localparam int LSP_DATA_TRANSLATION_BUFFER_STAGES = 1;
  localparam int LSP_PTR_LATENCY = LSP_ASU_STAGES + LSP_DATA_TRANSLATION_BUFFER_STAGES;
  // reset values
  localparam logic [63:0] LSP_ZERO64 = 64'h0000_0000_0000_0000;
  localparam logic [2:0] LSP_TAG_RESET = 3'h0;

  typedef enum logic [1:0] {
    LSP_ST_IDLE = 2'b00,
    LSP_ST_EXEC = 2'b01,
    LSP_ST_MISS = 2'b11
  } lsp_state_t;

  typedef enum logic [1:0] {
    LSP_K_LOAD = 2'b00,
    LSP_K_STORE = 2'b01,
    LSP_K_POSTINC = 2'b10,
    LSP_K_NONE = 2'b11
  } lsp_kind_t;
endpackage

// *** inc/lsp_ptr_if.sv ***
// carrier between the unit and its pointer update pipeline
`timescale 1ns/1ns
interface lsp_ptr_if;
  import lsp_pkg::*;
  logic start;
  logic [LSP_XLEN-1:0] ptr;
  logic [LSP_STEP_W-1:0] step;
  logic [LSP_REG_W-1:0] idx;
  logic [LSP_STREAM_W-1:0] stream;
  logic chk_hit;
  logic [LSP_XLEN-1:0] chk_addr;
  logic wb_valid;
  logic [LSP_REG_W-1:0] wb_idx;
  logic [LSP_XLEN-1:0] wb_data;
  logic pf_valid;
  logic [LSP_XLEN-1:0] pf_addr;
  logic [LSP_STREAM_W-1:0] pf_stream;
  logic dir_valid;
  logic dir_down;
  modport ctl (output start, ptr, step, idx, stream, chk_hit,
    input chk_addr, wb_valid, wb_idx, wb_data, pf_valid, pf_addr,
    pf_stream, dir_valid, dir_down);
  modport upd (input start, ptr, step, idx, stream, chk_hit,
    output chk_addr, wb_valid, wb_idx, wb_data, pf_valid, pf_addr,
    pf_stream, dir_valid, dir_down);
endinterface

// *** hdl/lsp_ptr_update.sv ***
// three-stage pointer update: two adder stages, one translation stage
`timescale 1ns/1ns
module lsp_ptr_update (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  lsp_ptr_if.upd pu
);
  import lsp_pkg::*;

  logic [LSP_XLEN-1:0] step_sx;
  logic a1_valid_r;
  logic [32:0] a1_lo_r;
  logic [31:0] a1_ha_r;
  logic [31:0] a1_hb_r;
  logic [LSP_REG_W-1:0] a1_idx_r;
  logic [LSP_STREAM_W-1:0] a1_str_r;
  logic a2_valid_r;
  logic [LSP_XLEN-1:0] a2_sum_r;
  logic [LSP_REG_W-1:0] a2_idx_r;
  logic [LSP_STREAM_W-1:0] a2_str_r;
  logic wb_valid_r;
  logic [LSP_REG_W-1:0] wb_idx_r;
  logic [LSP_XLEN-1:0] wb_data_r;
  logic pf_valid_r;
  logic [LSP_XLEN-1:0] pf_addr_r;
  logic [LSP_STREAM_W-1:0] pf_str_r;
  logic dir_valid_r;
  logic dir_down_r;

  // ninth bit carries the sign of the step
  assign step_sx = {{(LSP_XLEN-LSP_STEP_W){pu.step[LSP_STEP_W-1]}},
    pu.step};

  // adder stage one: low half with carry out, wraps modulo 2^64
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      a1_valid_r <= 1'b0;
      a1_lo_r <= 33'h0_0000_0000;
      a1_ha_r <= 32'h0000_0000;
      a1_hb_r <= 32'h0000_0000;
      a1_idx_r <= LSP_NULL_REGISTER;
      a1_str_r <= LSP_TAG_RESET;
    end else begin
      a1_valid_r <= pu.start;
      a1_lo_r <= {1'b0, pu.ptr[31:0]} + {1'b0, step_sx[31:0]};
      a1_ha_r <= pu.ptr[63:32];
      a1_hb_r <= step_sx[63:32];
      a1_idx_r <= pu.idx;
      a1_str_r <= pu.stream;
    end
  end

  // adder stage two: high half, carry in, no saturation
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      a2_valid_r <= 1'b0;
      a2_sum_r <= LSP_ZERO64;
      a2_idx_r <= LSP_NULL_REGISTER;
      a2_str_r <= LSP_TAG_RESET;
    end else begin
      a2_valid_r <= a1_valid_r;
      a2_sum_r <= {a1_ha_r + a1_hb_r + {31'h0000_0000, a1_lo_r[32]},
        a1_lo_r[31:0]};
      a2_idx_r <= a1_idx_r;
      a2_str_r <= a1_str_r;
    end
  end

  // translation stage: early check, then write back and prefetch
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      wb_valid_r <= 1'b0;
      wb_idx_r <= LSP_NULL_REGISTER;
      wb_data_r <= LSP_ZERO64;
      pf_valid_r <= 1'b0;
      pf_addr_r <= LSP_ZERO64;
      pf_str_r <= LSP_TAG_RESET;
    end else begin
      wb_valid_r <= a2_valid_r;
      wb_idx_r <= a2_idx_r;
      wb_data_r <= a2_sum_r;
      pf_valid_r <= a2_valid_r & pu.chk_hit;
      pf_addr_r <= a2_sum_r;
      pf_str_r <= a2_str_r;
    end
  end

  // direction hint from the step sign, one cycle after start
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      dir_valid_r <= 1'b0;
      dir_down_r <= 1'b0;
    end else begin
      dir_valid_r <= pu.start;
      dir_down_r <= pu.step[LSP_STEP_W-1];
    end
  end

  assign pu.chk_addr = a2_sum_r;
  assign pu.wb_valid = wb_valid_r;
  assign pu.wb_idx = wb_idx_r;
  assign pu.wb_data = wb_data_r;
  assign pu.pf_valid = pf_valid_r;
  assign pu.pf_addr = pf_addr_r;
  assign pu.pf_stream = pf_str_r;
  assign pu.dir_valid = dir_valid_r;
  assign pu.dir_down = dir_down_r;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  a_ptr_three_cycles: assert property (
    pu.start |-> ##3 (pu.wb_valid && pu.wb_data ==
      $past(pu.ptr, 3) + $past(step_sx, 3)))
    else $error("pointer update not written three cycles after start");

  a_dir_predict: assert property (
    pu.start |=> (pu.dir_valid && pu.dir_down == $past(pu.step[8])))
    else $error("direction hint does not follow step sign");
endmodule

// *** hdl/lsp_unit.sv ***
// load, store and post-increment load execution unit
// Contract
// - load reads item at pointer, reorders bytes, writes sized item
// - store reorders data bytes and writes sized item at pointer
// - bit 21 selects byte order: zero little, one big endian
// - pointer low bits significant for the size raise alignment fault
// - pointer not mapped in translation buffer raises page fault
// - alignment fault is reported ahead of page fault
// - load into null register suppresses faults and becomes prefetch
// - prefetch prepares memory hierarchy and hidden fault state
// - store free while buffer line free, else hold at decode
// - load hitting the memory buffer completes in two cycles
// - one memory operation issued per clock at peak
// - opcode 31..24, flags 23..18, pointer 11..6, data 5..0
// - post-increment load also writes pointer plus immediate
// - immediate in 19..12, bit 20 its sign bit
// - pointer addition wraps modulo address space, no saturation
// - updated pointer checked early; prefetch once translated
// - immediate sign predicts pointer direction for memory buffer
// - hidden per-register tag links pointer to stream number
// - pointer update takes three cycles: two add, one translate
`timescale 1ns/1ns
module lsp_unit (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic ins_valid_in,
  input wire logic [31:0] ins_word_in,
  input wire logic [lsp_pkg::LSP_XLEN-1:0] ins_ptr_in,
  input wire logic [lsp_pkg::LSP_XLEN-1:0] ins_data_in,
  output logic ins_ready_out,
  output logic [lsp_pkg::LSP_XLEN-1:0] tlb_addr_out,
  input wire logic tlb_hit_in,
  output logic [lsp_pkg::LSP_XLEN-1:0] chk_addr_out,
  input wire logic chk_hit_in,
  output logic mem_rd_req_out,
  output logic [lsp_pkg::LSP_XLEN-1:0] mem_rd_addr_out,
  input wire logic mem_rd_done_in,
  input wire logic [lsp_pkg::LSP_XLEN-1:0] mem_rd_data_in,
  output logic mem_wr_valid_out,
  input wire logic mem_wr_ready_in,
  output logic [lsp_pkg::LSP_XLEN-1:0] mem_wr_addr_out,
  output logic [lsp_pkg::LSP_XLEN-1:0] mem_wr_data_out,
  output logic [lsp_pkg::LSP_BE_W-1:0] mem_wr_be_out,
  output logic mem_pf_valid_out,
  output logic [lsp_pkg::LSP_XLEN-1:0] mem_pf_addr_out,
  output logic [lsp_pkg::LSP_STREAM_W-1:0] mem_pf_stream_out,
  output logic mem_dir_valid_out,
  output logic mem_dir_down_out,
  output logic tlb_fill_hint_out,
  output logic wb_dst_valid_out,
  output logic [lsp_pkg::LSP_REG_W-1:0] wb_dst_idx_out,
  output logic [lsp_pkg::LSP_XLEN-1:0] wb_dst_data_out,
  output logic wb_ptr_valid_out,
  output logic [lsp_pkg::LSP_REG_W-1:0] wb_ptr_idx_out,
  output logic [lsp_pkg::LSP_XLEN-1:0] wb_ptr_data_out,
  output logic fault_align_out,
  output logic fault_page_out,
  output logic [lsp_pkg::LSP_XLEN-1:0] fault_addr_out
);
  import lsp_pkg::*;

  // byte reorder within an item of the given size, item in low bytes
  function automatic logic [LSP_XLEN-1:0] lsp_reorder(
    input logic [LSP_XLEN-1:0] d, input logic [1:0] sz, input logic big);
    logic [LSP_XLEN-1:0] r;
    int n;
    r = LSP_ZERO64;
    n = 1 << sz;
    for (int i = 0; i < LSP_BE_W; i++) begin
      if (i < n) begin
        r[8*i +: 8] = big ? d[8*(n-1-i) +: 8] : d[8*i +: 8];
      end
    end
    return r;
  endfunction

  lsp_ptr_if pu();

  lsp_state_t state_r;
  lsp_state_t state_nxt;
  lsp_kind_t dec_kind;
  lsp_kind_t s1_kind_r;
  logic [7:0] dec_opc;
  logic [1:0] dec_size;
  logic dec_big;
  logic [LSP_REG_W-1:0] dec_ptr_idx;
  logic [LSP_REG_W-1:0] dec_dat_idx;
  logic ins_fire;
  logic [1:0] s1_size_r;
  logic s1_big_r;
  logic s1_pref_r;
  logic [LSP_XLEN-1:0] s1_ptr_r;
  logic [LSP_XLEN-1:0] s1_data_r;
  logic [LSP_REG_W-1:0] s1_ptr_idx_r;
  logic [LSP_REG_W-1:0] s1_dat_idx_r;
  logic [LSP_STEP_W-1:0] s1_step_r;
  logic [LSP_STREAM_W-1:0] s1_hint_r;
  logic [LSP_STREAM_W-1:0] tag_r [2**LSP_REG_W];
  logic [2:0] align_mask;
  logic in_exec;
  logic is_read;
  logic align_f;
  logic page_f;
  logic fault_any;
  logic load_go;
  logic load_take;
  logic exec_done;
  logic [LSP_XLEN-1:0] rd_item;
  logic wb_dst_valid_r;
  logic [LSP_REG_W-1:0] wb_dst_idx_r;
  logic [LSP_XLEN-1:0] wb_dst_data_r;
  logic fault_align_r;
  logic fault_page_r;
  logic [LSP_XLEN-1:0] fault_addr_r;
  logic pf_valid_r;
  logic [LSP_XLEN-1:0] pf_addr_r;
  logic [LSP_STREAM_W-1:0] pf_str_r;
  logic fill_hint_r;
  logic [LSP_XLEN-1:0] pf_miss_addr_r;

  // field decode of the incoming word
  assign dec_opc = ins_word_in[LSP_OPC_HI:LSP_OPC_LO];
  assign dec_size = ins_word_in[LSP_SIZE_HI:LSP_SIZE_LO];
  assign dec_big = ins_word_in[LSP_ENDIAN_BIT];
  assign dec_ptr_idx = ins_word_in[LSP_PTR_HI:LSP_PTR_LO];
  assign dec_dat_idx = ins_word_in[LSP_DAT_HI:LSP_DAT_LO];

  // opcode to operation kind
  always_comb begin
    unique case (dec_opc)
      LSP_PLAIN_READ_OPCODE: dec_kind = LSP_K_LOAD;
      LSP_PLAIN_WRITE_OPCODE: dec_kind = LSP_K_STORE;
      LSP_POSTINC_READ_OPCODE: dec_kind = LSP_K_POSTINC;
      default: dec_kind = LSP_K_NONE;
    endcase
  end

  assign ins_fire = ins_valid_in & ins_ready_out & (dec_kind != LSP_K_NONE);

  // decode stage register, one word per clock
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      s1_kind_r <= LSP_K_NONE;
      s1_size_r <= LSP_SZ_8;
      s1_big_r <= LSP_LITTLE_ENDIAN;
      s1_pref_r <= 1'b0;
      s1_ptr_r <= LSP_ZERO64;
      s1_data_r <= LSP_ZERO64;
      s1_ptr_idx_r <= LSP_NULL_REGISTER;
      s1_dat_idx_r <= LSP_NULL_REGISTER;
      s1_step_r <= 9'h000;
      s1_hint_r <= LSP_TAG_RESET;
    end else if (ins_fire) begin
      s1_kind_r <= dec_kind;
      s1_size_r <= dec_size;
      s1_big_r <= dec_big;
      s1_pref_r <= (dec_kind != LSP_K_STORE) &&
        (dec_dat_idx == LSP_NULL_REGISTER);
      s1_ptr_r <= ins_ptr_in;
      s1_data_r <= lsp_reorder(ins_data_in, dec_size, dec_big);
      s1_ptr_idx_r <= dec_ptr_idx;
      s1_dat_idx_r <= dec_dat_idx;
      s1_step_r <= {ins_word_in[LSP_IMM_SIGN],
        ins_word_in[LSP_IMM_HI:LSP_IMM_LO]};
      s1_hint_r <= ins_word_in[LSP_HINT_HI:LSP_HINT_LO];
    end
  end

  // hidden stream tag per register, set by plain accesses
  for (genvar g = 0; g < 2**LSP_REG_W; g++) begin : g_tag
    always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
        tag_r[g] <= LSP_TAG_RESET;
      end else if (ins_fire && dec_kind != LSP_K_POSTINC &&
          dec_ptr_idx == LSP_REG_W'(g)) begin
        tag_r[g] <= ins_word_in[LSP_HINT_HI:LSP_HINT_LO];
      end
    end
  end

  // low pointer bits that must be clear for each size
  always_comb begin
    unique case (s1_size_r)
      LSP_SZ_8: align_mask = 3'h0;
      LSP_SZ_16: align_mask = 3'h1;
      LSP_SZ_32: align_mask = 3'h3;
      LSP_SZ_64: align_mask = 3'h7;
    endcase
  end

  // fault detection with priority and prefetch suppression
  assign in_exec = (state_r == LSP_ST_EXEC);
  assign is_read = (s1_kind_r != LSP_K_STORE);
  assign align_f = in_exec && !s1_pref_r &&
    ((s1_ptr_r[2:0] & align_mask) != 3'h0);
  assign page_f = in_exec && !s1_pref_r && !align_f &&
    !tlb_hit_in;
  assign fault_any = align_f | page_f;
  assign load_go = in_exec && is_read && !s1_pref_r && !fault_any;
  assign load_take = (load_go || state_r == LSP_ST_MISS) && mem_rd_done_in;
  assign rd_item = lsp_reorder(mem_rd_data_in, s1_size_r, s1_big_r);

  // an operation leaves the execute slot this cycle
  always_comb begin
    exec_done = 1'b0;
    if (in_exec) begin
      if (fault_any || s1_pref_r) begin
        exec_done = 1'b1;
      end else if (s1_kind_r == LSP_K_STORE) begin
        exec_done = mem_wr_ready_in;
      end else begin
        exec_done = mem_rd_done_in;
      end
    end else if (state_r == LSP_ST_MISS) begin
      exec_done = mem_rd_done_in;
    end
  end

  // sequencing of the execute slot
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      LSP_ST_IDLE: state_nxt = ins_fire ? LSP_ST_EXEC : LSP_ST_IDLE;
      LSP_ST_EXEC, LSP_ST_MISS: begin
        if (exec_done) begin
          state_nxt = ins_fire ? LSP_ST_EXEC : LSP_ST_IDLE;
        end else if (in_exec && is_read) begin
          state_nxt = LSP_ST_MISS;
        end
      end
      default: state_nxt = LSP_ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state_r <= LSP_ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // decode holds while a store waits or a load misses
  assign ins_ready_out = (state_r == LSP_ST_IDLE) | exec_done;

  // memory requests, never issued for a faulting access
  assign tlb_addr_out = s1_ptr_r;
  assign mem_rd_req_out = load_go || (state_r == LSP_ST_MISS);
  assign mem_rd_addr_out = s1_ptr_r;
  assign mem_wr_valid_out = in_exec && (s1_kind_r == LSP_K_STORE) &&
    !fault_any;
  assign mem_wr_addr_out = s1_ptr_r;
  assign mem_wr_data_out = s1_data_r;
  assign mem_wr_be_out = (s1_size_r == LSP_SZ_8) ? 8'h01 :
    (s1_size_r == LSP_SZ_16) ? 8'h03 :
    (s1_size_r == LSP_SZ_32) ? 8'h0F : 8'hFF;

  // destination write back of the reordered item
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      wb_dst_valid_r <= 1'b0;
      wb_dst_idx_r <= LSP_NULL_REGISTER;
      wb_dst_data_r <= LSP_ZERO64;
    end else begin
      wb_dst_valid_r <= load_take;
      wb_dst_idx_r <= s1_dat_idx_r;
      wb_dst_data_r <= rd_item;
    end
  end

  // fault report pulses, address of the faulting pointer
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      fault_align_r <= 1'b0;
      fault_page_r <= 1'b0;
      fault_addr_r <= LSP_ZERO64;
    end else begin
      fault_align_r <= align_f;
      fault_page_r <= page_f;
      if (fault_any) begin
        fault_addr_r <= s1_ptr_r;
      end
    end
  end

  // prefetch requests and hidden fault preparation
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      pf_valid_r <= 1'b0;
      pf_addr_r <= LSP_ZERO64;
      pf_str_r <= LSP_TAG_RESET;
      fill_hint_r <= 1'b0;
      pf_miss_addr_r <= LSP_ZERO64;
    end else begin
      fill_hint_r <= in_exec && s1_pref_r && !tlb_hit_in;
      if (in_exec && s1_pref_r) begin
        pf_valid_r <= 1'b1;
        pf_addr_r <= s1_ptr_r;
        pf_str_r <= (s1_kind_r == LSP_K_POSTINC) ?
          tag_r[s1_ptr_idx_r] : s1_hint_r;
        if (!tlb_hit_in) begin
          pf_miss_addr_r <= s1_ptr_r;
        end
      end else begin
        pf_valid_r <= pu.pf_valid;
        pf_addr_r <= pu.pf_addr;
        pf_str_r <= pu.pf_stream;
      end
    end
  end

  // pointer update starts only for a fault-free post-increment
  assign pu.start = in_exec && (s1_kind_r == LSP_K_POSTINC) &&
    !fault_any;
  assign pu.ptr = s1_ptr_r;
  assign pu.step = s1_step_r;
  assign pu.idx = s1_ptr_idx_r;
  assign pu.stream = tag_r[s1_ptr_idx_r];
  assign pu.chk_hit = chk_hit_in;

  lsp_ptr_update u_ptr (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .pu(pu)
  );

  assign chk_addr_out = pu.chk_addr;
  assign wb_ptr_valid_out = pu.wb_valid;
  assign wb_ptr_idx_out = pu.wb_idx;
  assign wb_ptr_data_out = pu.wb_data;
  assign mem_dir_valid_out = pu.dir_valid;
  assign mem_dir_down_out = pu.dir_down;
  assign mem_pf_valid_out = pf_valid_r;
  assign mem_pf_addr_out = pf_addr_r;
  assign mem_pf_stream_out = pf_str_r;
  assign tlb_fill_hint_out = fill_hint_r;
  assign wb_dst_valid_out = wb_dst_valid_r;
  assign wb_dst_idx_out = wb_dst_idx_r;
  assign wb_dst_data_out = wb_dst_data_r;
  assign fault_align_out = fault_align_r;
  assign fault_page_out = fault_page_r;
  assign fault_addr_out = fault_addr_r;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  sequence s_issue_read;
    ins_fire && dec_kind == LSP_K_LOAD && dec_dat_idx != LSP_NULL_REGISTER;
  endsequence

  sequence s_buffer_hit;
    mem_rd_done_in && !fault_any;
  endsequence

  a_hit_two_cycles: assert property (
    s_issue_read ##1 s_buffer_hit |=> wb_dst_valid_out)
    else $error("buffer hit load not written two cycles after issue");

  a_load_data: assert property (
    load_take |=> wb_dst_data_out == $past(rd_item) &&
      wb_dst_idx_out == $past(s1_dat_idx_r))
    else $error("load write back data or index wrong");

  a_align_fault: assert property (
    (in_exec && !s1_pref_r && s1_ptr_r[0] && s1_size_r != LSP_SZ_8)
      |=> fault_align_out)
    else $error("odd pointer did not raise alignment fault");

  a_fault_order: assert property (
    fault_align_out |-> !fault_page_out)
    else $error("page fault reported with alignment fault");

  a_page_fault: assert property (
    (in_exec && !s1_pref_r && !align_f && !tlb_hit_in) |=>
      fault_page_out && fault_addr_out == $past(s1_ptr_r))
    else $error("unmapped pointer did not raise page fault");

  a_prefetch_quiet: assert property (
    (in_exec && s1_pref_r) |=> !fault_align_out && !fault_page_out &&
      !wb_dst_valid_out && mem_pf_valid_out)
    else $error("prefetch raised fault or wrote destination");

  a_fault_no_effect: assert property (
    fault_any |-> !mem_wr_valid_out && !pu.start && !mem_rd_req_out
      ##1 !wb_dst_valid_out)
    else $error("faulting access changed state");

  a_store_hold: assert property (
    (mem_wr_valid_out && !mem_wr_ready_in) |-> !ins_ready_out
      ##1 in_exec)
    else $error("decode not held while store waits");

  a_issue_rate: assert property (
    (mem_wr_valid_out && mem_wr_ready_in) |-> ins_ready_out)
    else $error("accepted store blocked next issue");

  a_store_data: assert property (
    (ins_fire && dec_kind == LSP_K_STORE) |=> mem_wr_data_out ==
      lsp_reorder($past(ins_data_in), $past(dec_size), $past(dec_big)))
    else $error("store data not reordered");
endmodule

// *** bench/lsp_mem_model.sv ***
// far side model: memory buffer and translation buffers
`timescale 1ns/1ns
module lsp_mem_model (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic slow_in,
  input wire logic stall_in,
  input wire logic [63:0] tlb_in,
  input wire logic [63:0] chk_in,
  input wire logic req_in,
  input wire logic [63:0] rda_in,
  output logic tlb_hit_out,
  output logic chk_hit_out,
  output logic done_out,
  output logic [63:0] rdd_out,
  output logic wr_rdy_out
);
  logic [1:0] wait_r;
  function automatic logic [63:0] word(input logic [63:0] a);
    return {a[31:0], a[31:0]} ^ 64'h0123_4567_89ab_cdef;
  endfunction
  // top nibble a marks an unmapped page
  assign tlb_hit_out = tlb_in[63:60] != 4'ha;
  assign chk_hit_out = chk_in[63:60] != 4'ha;
  assign wr_rdy_out = !stall_in;
  // hit answers at once, miss later; idle data is inverted
  assign done_out = req_in && (!slow_in || wait_r == 2'h3);
  assign rdd_out = done_out ? word(rda_in) : ~word(rda_in);
  // cycles spent on the current read
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || !req_in) begin
      wait_r <= 2'h0;
    end else if (wait_r != 2'h3) begin
      wait_r <= wait_r + 2'h1;
    end
  end
endmodule

// *** bench/lsp_unit_tb.sv ***
// self-checking bench of the load/store pointer unit
`timescale 1ns/1ns
module lsp_unit_tb;
  import lsp_pkg::*;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic ins_valid_in = 1'b0;
  logic [31:0] ins_word_in = 32'h0000_0000;
  logic [63:0] ins_ptr_in = 64'h0000_0000_0000_0000;
  logic [63:0] ins_data_in = 64'h0000_0000_0000_0000;
  logic slow = 1'b0;
  logic stall = 1'b0;
  logic ins_ready_out, tlb_hit_in, chk_hit_in, mem_rd_req_out;
  logic mem_rd_done_in, mem_wr_valid_out, mem_wr_ready_in;
  logic mem_pf_valid_out, mem_dir_valid_out, mem_dir_down_out;
  logic tlb_fill_hint_out, wb_dst_valid_out, wb_ptr_valid_out;
  logic fault_align_out, fault_page_out;
  logic [63:0] tlb_addr_out, chk_addr_out, mem_rd_addr_out;
  logic [63:0] mem_rd_data_in, mem_wr_addr_out, mem_wr_data_out;
  logic [63:0] mem_pf_addr_out, wb_dst_data_out, wb_ptr_data_out;
  logic [63:0] fault_addr_out;
  logic [7:0] mem_wr_be_out;
  logic [2:0] mem_pf_stream_out;
  logic [5:0] wb_dst_idx_out, wb_ptr_idx_out;
  int error_cnt = 0;
  int cmp_count = 0;
  int cycles = 0;
  lsp_unit dut (.sys_clk_in, .rst_in, .ins_valid_in, .ins_word_in,
    .ins_ptr_in, .ins_data_in, .ins_ready_out, .tlb_addr_out, .tlb_hit_in,
    .chk_addr_out, .chk_hit_in, .mem_rd_req_out, .mem_rd_addr_out,
    .mem_rd_done_in, .mem_rd_data_in, .mem_wr_valid_out, .mem_wr_ready_in,
    .mem_wr_addr_out, .mem_wr_data_out, .mem_wr_be_out, .mem_pf_valid_out,
    .mem_pf_addr_out, .mem_pf_stream_out, .mem_dir_valid_out,
    .mem_dir_down_out, .tlb_fill_hint_out, .wb_dst_valid_out,
    .wb_dst_idx_out, .wb_dst_data_out, .wb_ptr_valid_out, .wb_ptr_idx_out,
    .wb_ptr_data_out, .fault_align_out, .fault_page_out, .fault_addr_out);
  lsp_mem_model mem (.sys_clk_in, .rst_in, .slow_in(slow),
    .stall_in(stall), .tlb_in(tlb_addr_out), .chk_in(chk_addr_out),
    .req_in(mem_rd_req_out), .rda_in(mem_rd_addr_out),
    .tlb_hit_out(tlb_hit_in), .chk_hit_out(chk_hit_in),
    .done_out(mem_rd_done_in), .rdd_out(mem_rd_data_in),
    .wr_rdy_out(mem_wr_ready_in));
  always #25 sys_clk_in = ~sys_clk_in;
  // cut a hung run short
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      error_cnt++;
      close_out();
    end
  end
  task automatic close_out();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // offer a word from a rising edge, return at the edge that takes it
  task automatic issue(input logic [31:0] w, input logic [63:0] p, d);
    if (!sys_clk_in) begin
      @(posedge sys_clk_in);
    end
    ins_valid_in <= 1'b1;
    ins_word_in <= w;
    ins_ptr_in <= p;
    ins_data_in <= d;
    do @(posedge sys_clk_in); while (ins_ready_out !== 1'b1);
  endtask
  // drop the offer at the take edge, then step n cycle middles on
  task automatic at(input int n);
    if (sys_clk_in) begin
      ins_valid_in <= 1'b0;
    end
    repeat (n) @(negedge sys_clk_in);
  endtask
  // pointer register is always 9
  function automatic logic [31:0] mk(input logic [7:0] op,
    input logic [2:0] f, input logic [8:0] mid, input logic [5:0] d);
    return {op, f, mid, 6'h09, d};
  endfunction
  function automatic logic [63:0] ends(input logic [63:0] x,
    input int n, input logic big);
    ends = 64'h0000_0000_0000_0000;
    for (int i = 0; i < n; i++) begin
      ends[8*i+:8] = big ? x[8*(n-1-i)+:8] : x[8*i+:8];
    end
  endfunction
  task automatic flt(input logic [7:0] op, input logic [2:0] f,
    input logic [63:0] a, input logic [1:0] e);
    issue(mk(op, f, 9'h140, 6'h04), a, a);
    at(1);
    chk({mem_rd_req_out, mem_wr_valid_out}, 2'h0);
    at(1);
    chk({fault_align_out, fault_page_out}, e);
    chk(fault_addr_out, a);
    chk(wb_dst_valid_out, 1'h0);
  endtask
  initial begin
    logic [63:0] p;
    logic [63:0] x;
    p = 64'h0000_0000_0000_1000;
    repeat (16) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    @(negedge sys_clk_in);
    chk(ins_ready_out, 1'h1);
    // two loads back to back
    issue(mk(LSP_PLAIN_READ_OPCODE, 3'h6, 9'h140, 6'h01), p, p);
    issue(mk(LSP_PLAIN_READ_OPCODE, 3'h6, 9'h140, 6'h02), p + 8, p);
    at(1);
    chk(wb_dst_idx_out, 6'h01);
    at(1);
    chk(wb_dst_data_out, mem.word(p + 8));
    // every size in both byte orders
    for (int s = 0; s < 8; s++) begin
      issue(mk(LSP_PLAIN_READ_OPCODE, s[2:0], 9'h140, 6'h05), p, p);
      x = ends(mem.word(p), 1 << s[2:1], s[0]);
      at(2);
      chk(wb_dst_valid_out, 1'h1);
      chk(wb_dst_idx_out, 6'h05);
      chk(wb_dst_data_out, x);
    end
    // big-endian word store held by a full buffer
    stall <= 1'b1;
    x = 64'h1122_3344_5566_7788;
    issue(mk(LSP_PLAIN_WRITE_OPCODE, 3'h5, 9'h140, 6'h03), p, x);
    at(1);
    chk({ins_ready_out, mem_wr_valid_out}, 2'h1);
    chk(mem_wr_addr_out, p);
    chk(mem_wr_data_out, 64'h0000_0000_8877_6655);
    chk(mem_wr_be_out, 8'h0f);
    stall <= 1'b0;
    at(2);
    chk({ins_ready_out, mem_wr_valid_out}, 2'h2);
    flt(LSP_PLAIN_READ_OPCODE, 3'h2, 64'ha000_0000_0000_0001, 2'h2);
    flt(LSP_PLAIN_READ_OPCODE, 3'h6, 64'ha000_0000_0000_0000, 2'h1);
    flt(LSP_PLAIN_WRITE_OPCODE, 3'h6, p + 4, 2'h2);
    // prefetch into the null register
    issue(mk(LSP_PLAIN_READ_OPCODE, 3'h6, 9'h140, 6'h00),
      64'ha000_0000_0000_0003, p);
    at(1);
    chk(mem_rd_req_out, 1'h0);
    at(1);
    x = {fault_align_out, fault_page_out, mem_pf_valid_out};
    chk({x[2:0], tlb_fill_hint_out}, 4'h3);
    // post-increment from zero by minus eight
    x = 64'h0000_0000_0000_0000;
    issue(mk(LSP_POSTINC_READ_OPCODE, 3'h6, 9'h1f8, 6'h07), x, x);
    at(2);
    chk(wb_dst_data_out, mem.word(x));
    chk({mem_dir_valid_out, mem_dir_down_out}, 2'h3);
    at(1);
    chk(wb_ptr_valid_out, 1'h0);
    chk(chk_addr_out, 64'hffff_ffff_ffff_fff8);
    at(1);
    chk({wb_ptr_valid_out, wb_ptr_idx_out}, 7'h49);
    chk(wb_ptr_data_out, 64'hffff_ffff_ffff_fff8);
    at(1);
    chk({mem_pf_valid_out, mem_pf_stream_out}, 4'hd);
    chk(mem_pf_addr_out, 64'hffff_ffff_ffff_fff8);
    // load that misses the buffer
    slow <= 1'b1;
    issue(mk(LSP_PLAIN_READ_OPCODE, 3'h6, 9'h140, 6'h06), p, p);
    at(2);
    chk({ins_ready_out, wb_dst_valid_out}, 2'h0);
    chk(mem_rd_addr_out, p);
    chk(tlb_addr_out, p);
    while (wb_dst_valid_out !== 1'b1) at(1);
    chk(wb_dst_data_out, mem.word(p));
    close_out();
  end
endmodule
